// ==== hdl/bus_wait_state_control.sv ====
`timescale 1ns/1ps
module bus_wait_state_control (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      cfg_write,
  input  wait_ctl_pkg::wait_cfg_t        cfg_in,
  input  wire logic                      expansion_mode,
  input  wire logic                      access_start,
  input  wait_ctl_pkg::access_req_t      access_req,
  input  wire logic                      ready_n,
  output wait_ctl_pkg::wait_cfg_t        cfg_out,
  output logic                           space_4mb,
  output logic                           busy,
  output logic                           access_done,
  output logic [3:0]                     chip_select_n,
  output logic [2:0]                     cycle_length
);
  import wait_ctl_pkg::*;

  // ==========================================================
  // Control register
  wait_cfg_t cfg_ff;
  wait_cfg_t nxt_cfg;

  // Load controls on software write
  always_comb begin
    nxt_cfg = cfg_write ? cfg_in : cfg_ff;
  end

  // Register the controls
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_ff.internal_wait_select      <= INT_WAIT_RESET;
      cfg_ff.register_area_wait_select <= REG_WAIT_RESET;
      cfg_ff.area_wait_disable         <= WAIT_DIS_RESET;
      cfg_ff.extended_wait_register    <= EXT_WAIT_RESET;
      cfg_ff.memory_space_select       <= SPACE_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg_out = cfg_ff;

  // Memory space decode, gated by the processor mode
  always_comb begin
    space_4mb = expansion_mode &&
                (cfg_ff.memory_space_select == SPACE_4MB);
  end

  // ==========================================================
  // Cycle length lookup
  logic [2:0] calc_cycles;

  cycle_length_calc u_calc (
    .cfg    (cfg_ff),
    .req    (access_req),
    .cycles (calc_cycles)
  );

  // ==========================================================
  // Access sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COUNT,
    ST_READY
  } seq_state_t;

  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  logic [2:0]  count_ff;
  logic [2:0]  nxt_count;
  logic [2:0]  length_ff;
  logic [2:0]  nxt_length;
  logic        waited_ff;
  logic        nxt_waited;
  logic [3:0]  cs_n_ff;
  logic [3:0]  nxt_cs_n;
  logic        done_ff;
  logic        nxt_done;
  logic        ext_access;
  logic        cs_allowed;

  // External area with a chip select in 1-Mbyte mode
  always_comb begin
    ext_access = access_req.area == AREA_EXTERNAL;
    cs_allowed = ext_access && !space_4mb;
  end

  // Next-state logic of the sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_count  = count_ff;
    nxt_length = length_ff;
    nxt_waited = waited_ff;
    nxt_cs_n   = cs_n_ff;
    nxt_done   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (access_start) begin
          nxt_length = calc_cycles;
          nxt_count  = CYC_ONE;
          nxt_waited = ext_access &&
                       !cfg_ff.area_wait_disable[access_req.area_index];
          nxt_cs_n   = 4'hF;
          if (cs_allowed) begin
            nxt_cs_n[access_req.area_index] = 1'b0;
          end
          if (calc_cycles == CYC_ONE) begin
            nxt_state = ST_READY;
          end else begin
            nxt_state = ST_COUNT;
          end
        end
      end
      ST_COUNT: begin
        nxt_count = count_ff + 3'h1;
        if (count_ff + 3'h1 == length_ff) begin
          nxt_state = ST_READY;
        end
      end
      ST_READY: begin
        if (!waited_ff || !ready_n) begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
          nxt_cs_n  = 4'hF;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Register the sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff  <= ST_IDLE;
      count_ff  <= 3'h0;
      length_ff <= 3'h0;
      waited_ff <= 1'b0;
      cs_n_ff   <= 4'hF;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      count_ff  <= nxt_count;
      length_ff <= nxt_length;
      waited_ff <= nxt_waited;
      cs_n_ff   <= nxt_cs_n;
      done_ff   <= nxt_done;
    end
  end

  // Outputs
  assign busy          = state_ff != ST_IDLE;
  assign access_done   = done_ff;
  assign chip_select_n = cs_n_ff;
  assign cycle_length  = length_ff;

  // ==========================================================
  // Checks
  sequence s_start_sfr_slow;
    access_start && state_ff == ST_IDLE && access_req.area == AREA_SFR
      && !cfg_ff.register_area_wait_select;
  endsequence

  property p_sfr_len;
    @(posedge core_clk) disable iff (reset)
    s_start_sfr_slow |=> cycle_length == CYC_THREE;
  endproperty
  a_sfr_len: assert property (p_sfr_len)
    else $error("register area length wrong");

  property p_int_len;
    @(posedge core_clk) disable iff (reset)
    (access_start && state_ff == ST_IDLE
     && access_req.area == AREA_INTERNAL)
    |=> cycle_length == (cfg_ff.internal_wait_select ? CYC_TWO : CYC_ONE);
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("internal length wrong");

  property p_int_done;
    @(posedge core_clk) disable iff (reset)
    (access_start && state_ff == ST_IDLE && access_req.area == AREA_INTERNAL
     && !cfg_ff.internal_wait_select) |=> ##1 access_done;
  endproperty
  a_int_done: assert property (p_int_done)
    else $error("zero-wait access not done");

  property p_cs_one_hot;
    @(posedge core_clk) disable iff (reset)
    (access_start && state_ff == ST_IDLE && cs_allowed)
    |=> $countones(~chip_select_n) == 1;
  endproperty
  a_cs_one_hot: assert property (p_cs_one_hot)
    else $error("chip select not single");

  property p_ready_hold;
    @(posedge core_clk) disable iff (reset)
    (state_ff == ST_READY && waited_ff && ready_n) |=> !access_done;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("cycle ended without ready");

  property p_space;
    @(posedge core_clk) disable iff (reset)
    !expansion_mode |-> !space_4mb;
  endproperty
  a_space: assert property (p_space)
    else $error("expansion outside expansion mode");

  property p_mux_len;
    @(posedge core_clk) disable iff (reset)
    (access_start && state_ff == ST_IDLE && ext_access
     && access_req.muxed_bus
     && !cfg_ff.internal_wait_select
     && cfg_ff.extended_wait_register[{access_req.area_index, 1'b0} +: 2]
        == EXT_WAIT_TWO)
    |=> cycle_length == CYC_THREE;
  endproperty
  a_mux_len: assert property (p_mux_len)
    else $error("multiplexed length wrong");

  property p_cfg_hold;
    @(posedge core_clk) disable iff (reset)
    !cfg_write |=> $stable(cfg_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("controls changed without write");
endmodule : bus_wait_state_control

// ==== hdl/cycle_length_calc.sv ====
`timescale 1ns/1ps
// ==========================================================
// Combinational bus-cycle length lookup
module cycle_length_calc (
  input  wait_ctl_pkg::wait_cfg_t   cfg,
  input  wait_ctl_pkg::access_req_t req,
  output logic [2:0]                cycles
);
  import wait_ctl_pkg::*;

  logic [1:0] ext_field;
  logic       wait_dis;

  // Select the per-area controls
  always_comb begin
    ext_field = cfg.extended_wait_register[{req.area_index, 1'b0} +: 2];
    wait_dis  = cfg.area_wait_disable[req.area_index];
  end

  // Cycle count from the four control fields
  always_comb begin
    cycles = CYC_TWO;
    case (req.area)
      AREA_SFR: begin
        cycles = cfg.register_area_wait_select ? CYC_TWO : CYC_THREE;
      end
      AREA_INTERNAL: begin
        cycles = cfg.internal_wait_select ? CYC_TWO : CYC_ONE;
      end
      AREA_EXTERNAL: begin
        if (req.muxed_bus) begin
          if (cfg.internal_wait_select) begin
            cycles = CYC_THREE;
          end else begin
            // Field 11b is taken as the longest setting
            cycles = (ext_field >= EXT_WAIT_THREE) ? CYC_FOUR
                                                   : CYC_THREE;
          end
        end else if (cfg.internal_wait_select) begin
          cycles = CYC_TWO;
        end else if (wait_dis) begin
          cycles = req.is_write ? CYC_TWO : CYC_ONE;
        end else begin
          case (ext_field)
            EXT_WAIT_ONE:   cycles = CYC_TWO;
            EXT_WAIT_TWO:   cycles = CYC_THREE;
            EXT_WAIT_THREE: cycles = CYC_FOUR;
            default:        cycles = CYC_FOUR;
          endcase
        end
      end
      default: cycles = CYC_ONE;
    endcase
  end
endmodule : cycle_length_calc

// ==== inc/wait_ctl_pkg.sv ====
package wait_ctl_pkg;
  // ==========================================================
  // Area codes
  typedef enum logic [1:0] {
    AREA_SFR,
    AREA_INTERNAL,
    AREA_EXTERNAL,
    AREA_NONE
  } area_t;

  // Extended wait field codes
  localparam logic [1:0] EXT_WAIT_ONE   = 2'h0;
  localparam logic [1:0] EXT_WAIT_TWO   = 2'h1;
  localparam logic [1:0] EXT_WAIT_THREE = 2'h2;

  // Memory space field codes
  localparam logic [1:0] SPACE_1MB = 2'h0;
  localparam logic [1:0] SPACE_4MB = 2'h3;

  // Reset values of the controls
  localparam logic       INT_WAIT_RESET  = 1'h0;
  localparam logic [3:0] WAIT_DIS_RESET  = 4'h0;
  localparam logic [7:0] EXT_WAIT_RESET  = 8'h00;
  localparam logic [1:0] SPACE_RESET     = 2'h0;
  localparam logic       REG_WAIT_RESET  = 1'h0;

  // Bus cycle lengths in bus clocks
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;

  // Number of chip-select areas
  localparam int AREA_COUNT = 4;

  // Wait controls written by software
  typedef struct packed {
    logic       internal_wait_select;
    logic       register_area_wait_select;
    logic [3:0] area_wait_disable;
    logic [7:0] extended_wait_register;
    logic [1:0] memory_space_select;
  } wait_cfg_t;

  // One access request
  typedef struct packed {
    area_t      area;
    logic [1:0] area_index;
    logic       is_write;
    logic       muxed_bus;
  } access_req_t;
endpackage : wait_ctl_pkg

// ==== verif/bus_wait_state_control_tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the wait-state control
module bus_wait_state_control_tb;
  import wait_ctl_pkg::*;
  logic        core_clk = 1'h0, reset = 1'h1, cfg_write = 1'h0;
  logic        expansion_mode = 1'h0, access_start = 1'h0;
  logic        ready_n, space_4mb, busy, access_done;
  wait_cfg_t   cfg_in = '0, cfg_out;
  access_req_t access_req = '0;
  logic [3:0]  chip_select_n, stall_cycles = 4'h0;
  logic [2:0]  cycle_length;
  int          bad_count = 0, num_checks = 0;

  always #2.5 core_clk = ~core_clk;

  bus_wait_state_control i_bus_wait_state_control (
    .core_clk(core_clk), .reset(reset), .cfg_write(cfg_write),
    .cfg_in(cfg_in), .expansion_mode(expansion_mode),
    .access_start(access_start), .access_req(access_req),
    .ready_n(ready_n), .cfg_out(cfg_out), .space_4mb(space_4mb),
    .busy(busy), .access_done(access_done),
    .chip_select_n(chip_select_n), .cycle_length(cycle_length));

  ext_ready_model i_ext_ready_model (
    .core_clk(core_clk), .chip_select_n(chip_select_n),
    .stall_cycles(stall_cycles), .ready_n(ready_n));

  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Load new controls and read them back
  task set_cfg(input logic iw, rw, input logic [3:0] dis,
               input logic [7:0] ext, input logic [1:0] sp);
    cfg_in = '{iw, rw, dis, ext, sp};
    cfg_write = 1'h1;
    @(posedge core_clk) #1;
    cfg_write = 1'h0;
    chk(cfg_out, cfg_in);
  endtask : set_cfg

  // One access; returns in the cycle where done is high
  task run(input area_t a, input logic [1:0] ix, input logic w, m,
           input logic [2:0] n, input logic [3:0] stall);
    int         cnt;
    logic [3:0] cs;
    cs = (a == AREA_EXTERNAL && !(expansion_mode &&
          cfg_in.memory_space_select == SPACE_4MB)) ? ~(4'h1 << ix) : 4'hF;
    stall_cycles = stall;
    access_req = '{a, ix, w, m};
    access_start = 1'h1;
    @(posedge core_clk) #1;
    access_start = 1'h0;
    chk(cycle_length, n);
    chk(chip_select_n, cs);
    chk(busy, 1'h1);
    cnt = 1;
    while (access_done !== 1'h1 && cnt < 40) begin
      @(posedge core_clk) #1;
      cnt++;
    end
    if (stall == 4'h0) chk(16'(cnt), 16'(n) + 16'h1);
    else chk(16'(cnt > int'(n) + 1), 16'h1);
    chk(chip_select_n, 4'hF);
    chk(busy, 1'h0);
  endtask : run

  // Verdict and end of run
  task test_done;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial begin
    #20000;
    bad_count++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    #1 reset = 1'h0;
    chk(cfg_out, 16'h0);
    chk(chip_select_n, 4'hF);
    run(AREA_INTERNAL, 2'h0, 1'h0, 1'h0, 3'h1, 4'h0);
    run(AREA_EXTERNAL, 2'h3, 1'h1, 1'h0, 3'h2, 4'h0);
    set_cfg(1'h1, 1'h1, 4'hF, 8'hFF, 2'h0);
    run(AREA_SFR, 2'h0, 1'h0, 1'h0, 3'h2, 4'h0);
    run(AREA_INTERNAL, 2'h0, 1'h1, 1'h0, 3'h2, 4'h0);
    set_cfg(1'h1, 1'h0, 4'hF, 8'hFF, 2'h0);
    run(AREA_SFR, 2'h0, 1'h1, 1'h0, 3'h3, 4'h0);
    set_cfg(1'h0, 1'h0, 4'hF, 8'h00, 2'h0);
    for (int i = 0; i < 4; i++) begin
      run(AREA_EXTERNAL, 2'(i), 1'h0, 1'h0, 3'h1, 4'h0);
      run(AREA_EXTERNAL, 2'(i), 1'h1, 1'h0, 3'h2, 4'h0);
    end
    set_cfg(1'h0, 1'h0, 4'h0, 8'h24, 2'h0);
    for (int i = 0; i < 3; i++) begin
      run(AREA_EXTERNAL, 2'(i), 1'h0, 1'h0, 3'(2 + i), 4'h0);
      run(AREA_EXTERNAL, 2'(i), 1'h1, 1'h1, i == 2 ? 3'h4 : 3'h3,
          4'h0);
    end
    set_cfg(1'h1, 1'h0, 4'h0, 8'h00, 2'h0);
    run(AREA_EXTERNAL, 2'h2, 1'h0, 1'h0, 3'h2, 4'h0);
    run(AREA_EXTERNAL, 2'h2, 1'h0, 1'h1, 3'h3, 4'h0);
    run(AREA_EXTERNAL, 2'h1, 1'h0, 1'h0, 3'h2, 4'h6);
    run(AREA_NONE, 2'h2, 1'h0, 1'h0, 3'h1, 4'h0);
    set_cfg(1'h0, 1'h0, 4'hF, 8'h00, 2'h3);
    chk(space_4mb, 1'h0);
    expansion_mode = 1'h1;
    @(posedge core_clk) #1;
    chk(space_4mb, 1'h1);
    run(AREA_EXTERNAL, 2'h1, 1'h0, 1'h0, 3'h1, 4'h0);
    expansion_mode = 1'h0;
    @(posedge core_clk) #1;
    chk(space_4mb, 1'h0);
    test_done();
  end
endmodule : bus_wait_state_control_tb

// ==== verif/ext_ready_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// External device answering on the ready line
module ext_ready_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] chip_select_n,
  input  wire logic [3:0] stall_cycles,
  output logic            ready_n
);
  logic [3:0] wait_ff;

  // Counts cycles while the device is selected
  always @(posedge core_clk) begin
    wait_ff <= (&chip_select_n) ? 4'h0 : wait_ff + 4'h1;
  end

  // Not ready until the stall count has run out; idle line rests high
  assign ready_n = (&chip_select_n) ? 1'b1
                                    : (wait_ff < stall_cycles);
endmodule : ext_ready_model
